// ===== t16_filter.sv
// shared constants for the timer core, and the four-sample input filter
`timescale 1ns/1ps
`default_nettype none

package t16_pkg;
    // cpu byte locations on the access port
    localparam logic [2:0] SEL_COUNT_LOWER = 3'h0;
    localparam logic [2:0] SEL_COUNT_UPPER = 3'h1;
    localparam logic [2:0] SEL_CAPTURE_LOWER = 3'h2;
    localparam logic [2:0] SEL_CAPTURE_UPPER = 3'h3;
    localparam logic [2:0] SEL_COMPARE_LOWER = 3'h4;
    localparam logic [2:0] SEL_COMPARE_UPPER = 3'h5;
    // clock source select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03F;
    localparam logic [9:0] DIV256_MASK = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;
    // counter extremes and fixed tops
    localparam logic [15:0] COUNT_FLOOR = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    // waveform modes
    localparam logic [3:0] WM_NORMAL = 4'h0;
    localparam logic [3:0] WM_PC8 = 4'h1;
    localparam logic [3:0] WM_PC9 = 4'h2;
    localparam logic [3:0] WM_PC10 = 4'h3;
    localparam logic [3:0] WM_CTC_CMP = 4'h4;
    localparam logic [3:0] WM_FAST8 = 4'h5;
    localparam logic [3:0] WM_FAST9 = 4'h6;
    localparam logic [3:0] WM_FAST10 = 4'h7;
    localparam logic [3:0] WM_PFC_CAP = 4'h8;
    localparam logic [3:0] WM_PFC_CMP = 4'h9;
    localparam logic [3:0] WM_PC_CAP = 4'hA;
    localparam logic [3:0] WM_PC_CMP = 4'hB;
    localparam logic [3:0] WM_CTC_CAP = 4'hC;
    localparam logic [3:0] WM_FAST_CAP = 4'hE;
    localparam logic [3:0] WM_FAST_CMP = 4'hF;
    // reset values
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [9:0] RESET_PRESC = 10'h000;
    // filter depth in system clock samples
    localparam int FILTER_SAMPLES = 4;
    localparam logic [3:0] FILTER_ALL_ONE = 4'hF;
    localparam logic [3:0] FILTER_ALL_ZERO = 4'h0;
endpackage : t16_pkg

module t16_filter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sample_in,
    output logic filtered_out
);
    typedef struct packed {
        logic [t16_pkg::FILTER_SAMPLES-1:0] hist;
        logic out;
    } t16_filt_t;

    t16_filt_t s;
    t16_filt_t next_s;

    // samples every system clock, independent of the prescaler
    // the incoming sample is the fourth one, so the delay stays at exactly four cycles
    always_comb begin
        next_s = s;
        next_s.hist = {s.hist[t16_pkg::FILTER_SAMPLES-2:0], sample_in};
        if (next_s.hist == t16_pkg::FILTER_ALL_ONE) begin
            next_s.out = 1'b1;
        end else if (next_s.hist == t16_pkg::FILTER_ALL_ZERO) begin
            next_s.out = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign filtered_out = s.out;

    filter_change_a: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(s.out) |-> (s.hist == {4{s.out}}))
        else $error("filter output moved without four equal samples");
endmodule : t16_filter

`default_nettype wire

// ===== t16_core.sv
// sixteen-bit timer counter with shared byte latch and input capture
// What this block does
// - three-bit clock source select; zero stops the counter.
// - sixteen-bit counter counts up, down or clears per tick, flags top and floor.
// - upper counter location is the latch; lower read fills it, lower write takes its upper byte from it.
// - a cpu counter write beats any count or clear in that cycle.
// - counter stays readable and writable with no tick source selected.
// - counting sequence follows the four-bit waveform mode, split in two fields.
// - overflow flag set at the mode's point and can request an interrupt.
// - chosen trigger edge copies the whole counter into the capture register.
// - capture flag set with the load; interrupt raised when enabled.
// - capture flag clears on interrupt service or a one written to it.
// - capture lower read fills the latch; upper read returns the latch.
// - capture register writable only in modes using it as top.
// - comparator select bit switches the trigger; software clears the flag afterwards.
// - both triggers synchronised and edge-detected; filter adds four cycles.
// - capture events blocked only in modes using capture as top; filter and edge detector keep running.
// - software driving the capture pin through its port also captures.
// - filter output moves only after four equal samples.
// - filter enable is a control bit; filter runs on the system clock.
// - each capture overwrites the register even if unread.
// - floor is zero, maximum is all ones; floor marks reaching zero.
// - top is a fixed value, compare register or capture register per mode.
// - compare reads come straight out and leave the latch alone.
`timescale 1ns/1ps
`default_nettype none

module t16_core (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CPU_RD,
    input wire logic CPU_WR,
    input wire logic [2:0] CPU_SEL,
    input wire logic [7:0] CPU_WDATA,
    output logic [7:0] CPU_RDATA,
    input wire logic [2:0] CLOCK_SOURCE_SELECT,
    input wire logic [1:0] WAVEFORM_MODE_SELECT_A,
    input wire logic [1:0] WAVEFORM_MODE_SELECT_B,
    input wire logic NOISE_FILTER_ENABLE,
    input wire logic EDGE_RISING,
    input wire logic COMPARATOR_TRIGGER_SELECT,
    input wire logic CAPTURE_IRQ_ENABLE,
    input wire logic OVERFLOW_IRQ_ENABLE,
    input wire logic CAPTURE_IRQ_ACK,
    input wire logic OVERFLOW_IRQ_ACK,
    input wire logic CAPTURE_FLAG_CLEAR,
    input wire logic OVERFLOW_FLAG_CLEAR,
    input wire logic EXTERNAL_COUNT_PIN,
    input wire logic CAPTURE_PIN,
    input wire logic CAPTURE_PORT_OUT,
    input wire logic CAPTURE_PORT_DIR,
    input wire logic COMPARATOR_OUTPUT,
    output logic [15:0] COUNT_VALUE,
    output logic [15:0] CAPTURE_VALUE,
    output logic [15:0] COMPARE_VALUE_A,
    output logic COUNT_AT_TOP,
    output logic COUNT_AT_FLOOR,
    output logic OVERFLOW_FLAG,
    output logic CAPTURE_FLAG,
    output logic OVERFLOW_IRQ,
    output logic CAPTURE_IRQ
);
    typedef struct packed {
        logic [15:0] count_value;
        logic dir_down;
        logic [7:0] latch;
        logic [15:0] capture_value;
        logic [15:0] compare_a;
        logic overflow_flag;
        logic capture_flag;
        logic overflow_irq;
        logic capture_irq;
        logic [7:0] rdata;
        logic at_top;
        logic at_floor;
        logic [9:0] presc;
        logic ext_s1;
        logic ext_s2;
        logic ext_prev;
        logic trig_s1;
        logic trig_s2;
        logic edge_prev;
    } t16_state_t;

    t16_state_t s;
    t16_state_t next_s;

    logic [3:0] wave_mode;
    logic dual_slope;
    logic capture_is_top;
    logic [15:0] top_value;
    logic tick;
    logic trig_raw;
    logic filt_out;
    logic edge_in;
    logic cap_event;
    logic wr_count;

    assign wave_mode = {WAVEFORM_MODE_SELECT_B, WAVEFORM_MODE_SELECT_A};
    assign wr_count = CPU_WR && (CPU_SEL == t16_pkg::SEL_COUNT_LOWER);

    // mode decode: slope style, top source
    always_comb begin
        dual_slope = 1'b0;
        capture_is_top = 1'b0;
        top_value = t16_pkg::COUNT_MAX;
        case (wave_mode)
            t16_pkg::WM_NORMAL: top_value = t16_pkg::COUNT_MAX;
            t16_pkg::WM_PC8: begin
                dual_slope = 1'b1;
                top_value = t16_pkg::TOP_8BIT;
            end
            t16_pkg::WM_PC9: begin
                dual_slope = 1'b1;
                top_value = t16_pkg::TOP_9BIT;
            end
            t16_pkg::WM_PC10: begin
                dual_slope = 1'b1;
                top_value = t16_pkg::TOP_10BIT;
            end
            t16_pkg::WM_CTC_CMP: top_value = s.compare_a;
            t16_pkg::WM_FAST8: top_value = t16_pkg::TOP_8BIT;
            t16_pkg::WM_FAST9: top_value = t16_pkg::TOP_9BIT;
            t16_pkg::WM_FAST10: top_value = t16_pkg::TOP_10BIT;
            t16_pkg::WM_PFC_CAP, t16_pkg::WM_PC_CAP: begin
                dual_slope = 1'b1;
                capture_is_top = 1'b1;
                top_value = s.capture_value;
            end
            t16_pkg::WM_PFC_CMP, t16_pkg::WM_PC_CMP: begin
                dual_slope = 1'b1;
                top_value = s.compare_a;
            end
            t16_pkg::WM_CTC_CAP, t16_pkg::WM_FAST_CAP: begin
                capture_is_top = 1'b1;
                top_value = s.capture_value;
            end
            t16_pkg::WM_FAST_CMP: top_value = s.compare_a;
            default: top_value = t16_pkg::COUNT_MAX;
        endcase
    end

    // tick from the prescaler or the synchronised count pin
    always_comb begin
        case (CLOCK_SOURCE_SELECT)
            t16_pkg::CS_STOP: tick = 1'b0;
            t16_pkg::CS_DIV1: tick = 1'b1;
            t16_pkg::CS_DIV8: tick = (s.presc & t16_pkg::DIV8_MASK) == t16_pkg::DIV8_MASK;
            t16_pkg::CS_DIV64: tick = (s.presc & t16_pkg::DIV64_MASK) == t16_pkg::DIV64_MASK;
            t16_pkg::CS_DIV256: tick = (s.presc & t16_pkg::DIV256_MASK) == t16_pkg::DIV256_MASK;
            t16_pkg::CS_DIV1024: tick = s.presc == t16_pkg::DIV1024_MASK;
            t16_pkg::CS_EXT_FALL: tick = s.ext_prev && !s.ext_s2;
            t16_pkg::CS_EXT_RISE: tick = !s.ext_prev && s.ext_s2;
            default: tick = 1'b0;
        endcase
    end

    // a pin driven as output by the port reads back the port value
    assign trig_raw = COMPARATOR_TRIGGER_SELECT ? COMPARATOR_OUTPUT
        : (CAPTURE_PORT_DIR ? CAPTURE_PORT_OUT : CAPTURE_PIN);

    t16_filter u_filter (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .sample_in(s.trig_s2),
        .filtered_out(filt_out)
    );

    assign edge_in = NOISE_FILTER_ENABLE ? filt_out : s.trig_s2;
    assign cap_event = !capture_is_top
        && (EDGE_RISING ? (edge_in && !s.edge_prev) : (!edge_in && s.edge_prev));

    always_comb begin
        next_s = s;
        next_s.presc = s.presc + 10'h001;
        next_s.ext_s1 = EXTERNAL_COUNT_PIN;
        next_s.ext_s2 = s.ext_s1;
        next_s.ext_prev = s.ext_s2;
        next_s.trig_s1 = trig_raw;
        next_s.trig_s2 = s.trig_s1;
        next_s.edge_prev = edge_in;
        next_s.at_top = 1'b0;
        next_s.at_floor = 1'b0;

        // clears first, so a set from the count below wins
        if (OVERFLOW_IRQ_ACK || OVERFLOW_FLAG_CLEAR) begin
            next_s.overflow_flag = 1'b0;
        end
        // counting; the overflow point depends on the slope style
        if (tick) begin
            if (dual_slope) begin
                if (!s.dir_down && s.count_value >= top_value) begin
                    next_s.dir_down = 1'b1;
                    next_s.count_value = s.count_value - 16'h0001;
                end else if (s.dir_down && s.count_value == t16_pkg::COUNT_FLOOR) begin
                    next_s.dir_down = 1'b0;
                    next_s.count_value = s.count_value + 16'h0001;
                end else if (s.dir_down) begin
                    next_s.count_value = s.count_value - 16'h0001;
                end else begin
                    next_s.count_value = s.count_value + 16'h0001;
                end
            end else begin
                next_s.dir_down = 1'b0;
                if (s.count_value == top_value || s.count_value == t16_pkg::COUNT_MAX) begin
                    next_s.count_value = t16_pkg::COUNT_FLOOR;
                end else begin
                    next_s.count_value = s.count_value + 16'h0001;
                end
            end
            if (dual_slope && s.dir_down && s.count_value == t16_pkg::COUNT_FLOOR) begin
                next_s.overflow_flag = 1'b1;
            end else if (!dual_slope && wave_mode != t16_pkg::WM_NORMAL
                         && wave_mode != t16_pkg::WM_CTC_CMP && wave_mode != t16_pkg::WM_CTC_CAP
                         && s.count_value == top_value) begin
                next_s.overflow_flag = 1'b1;
            end else if (!dual_slope && s.count_value == t16_pkg::COUNT_MAX) begin
                next_s.overflow_flag = 1'b1;
            end
        end

        // capture flag clear; a same-cycle capture below wins
        if (CAPTURE_IRQ_ACK || CAPTURE_FLAG_CLEAR) begin
            next_s.capture_flag = 1'b0;
        end

        // capture always overwrites, unread or not
        if (cap_event) begin
            next_s.capture_value = s.count_value;
            next_s.capture_flag = 1'b1;
        end

        // cpu byte access through the shared latch
        if (CPU_RD) begin
            case (CPU_SEL)
                t16_pkg::SEL_COUNT_LOWER: begin
                    next_s.rdata = s.count_value[7:0];
                    next_s.latch = s.count_value[15:8];
                end
                t16_pkg::SEL_CAPTURE_LOWER: begin
                    next_s.rdata = s.capture_value[7:0];
                    next_s.latch = s.capture_value[15:8];
                end
                t16_pkg::SEL_COUNT_UPPER, t16_pkg::SEL_CAPTURE_UPPER: next_s.rdata = s.latch;
                t16_pkg::SEL_COMPARE_LOWER: next_s.rdata = s.compare_a[7:0];
                t16_pkg::SEL_COMPARE_UPPER: next_s.rdata = s.compare_a[15:8];
                default: next_s.rdata = t16_pkg::RESET_BYTE;
            endcase
        end else if (CPU_WR) begin
            case (CPU_SEL)
                t16_pkg::SEL_COUNT_UPPER, t16_pkg::SEL_CAPTURE_UPPER,
                t16_pkg::SEL_COMPARE_UPPER: next_s.latch = CPU_WDATA;
                t16_pkg::SEL_COUNT_LOWER: next_s.count_value = {s.latch, CPU_WDATA};
                t16_pkg::SEL_CAPTURE_LOWER: begin
                    if (capture_is_top) begin
                        next_s.capture_value = {s.latch, CPU_WDATA};
                    end
                end
                t16_pkg::SEL_COMPARE_LOWER: next_s.compare_a = {s.latch, CPU_WDATA};
                default: next_s.latch = s.latch;
            endcase
        end

        next_s.at_top = (next_s.count_value == top_value);
        next_s.at_floor = (next_s.count_value == t16_pkg::COUNT_FLOOR);
        next_s.overflow_irq = next_s.overflow_flag && OVERFLOW_IRQ_ENABLE;
        next_s.capture_irq = next_s.capture_flag && CAPTURE_IRQ_ENABLE;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign CPU_RDATA = s.rdata;
    assign COUNT_VALUE = s.count_value;
    assign CAPTURE_VALUE = s.capture_value;
    assign COMPARE_VALUE_A = s.compare_a;
    assign COUNT_AT_TOP = s.at_top;
    assign COUNT_AT_FLOOR = s.at_floor;
    assign OVERFLOW_FLAG = s.overflow_flag;
    assign CAPTURE_FLAG = s.capture_flag;
    assign OVERFLOW_IRQ = s.overflow_irq;
    assign CAPTURE_IRQ = s.capture_irq;

    count_write_wins_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (wr_count && !CPU_RD) |=> (COUNT_VALUE == {$past(s.latch), $past(CPU_WDATA)}))
        else $error("cpu counter write lost");
    stopped_count_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CLOCK_SOURCE_SELECT == t16_pkg::CS_STOP && !CPU_WR) |=> $stable(COUNT_VALUE))
        else $error("counter moved while stopped");
    single_wrap_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (tick && !dual_slope && !CPU_WR && COUNT_VALUE == top_value) |=> COUNT_VALUE == t16_pkg::COUNT_FLOOR)
        else $error("counter did not wrap at top");
    capture_load_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (cap_event && !CPU_WR) |=> (CAPTURE_VALUE == $past(COUNT_VALUE)) && CAPTURE_FLAG)
        else $error("capture did not load counter and flag");
    capture_irq_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (cap_event && CAPTURE_IRQ_ENABLE) |=> CAPTURE_IRQ)
        else $error("capture interrupt not raised");
    capture_clear_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        ((CAPTURE_IRQ_ACK || CAPTURE_FLAG_CLEAR) && !cap_event) |=> !CAPTURE_FLAG)
        else $error("capture flag not cleared");
    latch_fill_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CPU_RD && CPU_SEL == t16_pkg::SEL_COUNT_LOWER) ##1 (!CPU_RD && !CPU_WR) ##1
        (CPU_RD && CPU_SEL == t16_pkg::SEL_COUNT_UPPER) |=> CPU_RDATA == $past(COUNT_VALUE[15:8], 3))
        else $error("counter upper read missed the latch");
    capture_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CPU_RD && CPU_SEL == t16_pkg::SEL_CAPTURE_LOWER) |=> s.latch == $past(CAPTURE_VALUE[15:8]))
        else $error("capture lower read did not fill latch");
    capture_guard_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CPU_WR && CPU_SEL == t16_pkg::SEL_CAPTURE_LOWER && !capture_is_top && !cap_event)
        |=> $stable(CAPTURE_VALUE))
        else $error("capture register written in wrong mode");
    compare_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (CPU_RD && CPU_SEL == t16_pkg::SEL_COMPARE_UPPER) |=> $stable(s.latch) && CPU_RDATA == COMPARE_VALUE_A[15:8])
        else $error("compare read touched the latch");
    capture_gate_a: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        (capture_is_top && !CAPTURE_FLAG && !(CPU_WR && CPU_SEL == t16_pkg::SEL_CAPTURE_LOWER))
        |=> !CAPTURE_FLAG && $stable(CAPTURE_VALUE))
        else $error("capture fired in capture-top mode");
endmodule : t16_core

`default_nettype wire

// ===== t16_cpu_model.sv
// cpu side model driving the byte access port of the timer core
`timescale 1ns/1ps
`default_nettype none

module t16_cpu_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic rd,
    output logic wr,
    output logic [2:0] sel,
    output logic [7:0] wdata
);
    initial begin
        rd = 1'b0;
        wr = 1'b0;
        sel = 3'h0;
        wdata = 8'h00;
    end

    task automatic wr8(input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        #1;
        wr = 1'b1;
        sel = s;
        wdata = d;
        @(posedge clk);
        #1;
        wr = 1'b0;
        // released data is scrambled so a late sample cannot pass
        wdata = ~d;
    endtask : wr8

    task automatic rd8(input logic [2:0] s, output logic [7:0] d);
        @(posedge clk);
        #1;
        rd = 1'b1;
        sel = s;
        @(posedge clk);
        #1;
        rd = 1'b0;
        d = rdata;
    endtask : rd8

    // upper byte first so the latch holds it when the lower write commits
    task automatic wr16(input logic [2:0] lo, input logic [15:0] v);
        wr8(lo + 3'h1, v[15:8]);
        wr8(lo, v[7:0]);
    endtask : wr16

    task automatic rd16(input logic [2:0] lo, output logic [15:0] v);
        rd8(lo, v[7:0]);
        rd8(lo + 3'h1, v[15:8]);
    endtask : rd16
endmodule : t16_cpu_model

`default_nettype wire

// ===== timer16_counter_capture_tb_top.sv
// self-checking bench for the timer core
`timescale 1ns/1ps
`default_nettype none

module timer16_counter_capture_tb_top;
    logic clk, rst_n, rd, wr, nf, er, cts, cie, oie, cack, oack, cclr, oclr, ext, pin, pout, pdir, cmp;
    logic at_top, at_floor, ovf, capf, oirq, cirq;
    logic [2:0] sel, cs;
    logic [1:0] wm_a, wm_b;
    logic [7:0] wdata, rdata, b;
    logic [15:0] cnt, cap, cmpa, r;
    int mismatches, compares, n0, n1;

    t16_cpu_model i_cpu (.clk(clk), .rdata(rdata), .rd(rd), .wr(wr), .sel(sel), .wdata(wdata));

    t16_core i_dut (.CORE_CLK(clk), .RST_N(rst_n), .CPU_RD(rd), .CPU_WR(wr), .CPU_SEL(sel),
        .CPU_WDATA(wdata), .CPU_RDATA(rdata), .CLOCK_SOURCE_SELECT(cs), .WAVEFORM_MODE_SELECT_A(wm_a),
        .WAVEFORM_MODE_SELECT_B(wm_b), .NOISE_FILTER_ENABLE(nf), .EDGE_RISING(er),
        .COMPARATOR_TRIGGER_SELECT(cts), .CAPTURE_IRQ_ENABLE(cie), .OVERFLOW_IRQ_ENABLE(oie),
        .CAPTURE_IRQ_ACK(cack), .OVERFLOW_IRQ_ACK(oack), .CAPTURE_FLAG_CLEAR(cclr),
        .OVERFLOW_FLAG_CLEAR(oclr), .EXTERNAL_COUNT_PIN(ext), .CAPTURE_PIN(pin),
        .CAPTURE_PORT_OUT(pout), .CAPTURE_PORT_DIR(pdir), .COMPARATOR_OUTPUT(cmp),
        .COUNT_VALUE(cnt), .CAPTURE_VALUE(cap), .COMPARE_VALUE_A(cmpa), .COUNT_AT_TOP(at_top),
        .COUNT_AT_FLOOR(at_floor), .OVERFLOW_FLAG(ovf), .CAPTURE_FLAG(capf), .OVERFLOW_IRQ(oirq),
        .CAPTURE_IRQ(cirq));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic wt(ref logic s, input int lim, output int n);
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
        if (s !== 1'b1) begin
            mismatches++;
            $display("[ERR] t=%0t wait ran out got %h exp %h", $time, s, 1'b1);
            test_done();
        end
    endtask : wt

    task automatic clrcap;
        cclr = 1'b1;
        tick(1);
        cclr = 1'b0;
        tick(1);
    endtask : clrcap

    task automatic t_access;
        i_cpu.wr16(t16_pkg::SEL_COUNT_LOWER, 16'h1234);
        tick(3);
        chk(cnt, 16'h1234);
        i_cpu.rd16(t16_pkg::SEL_COUNT_LOWER, r);
        chk(r, 16'h1234);
        i_cpu.wr8(t16_pkg::SEL_COMPARE_LOWER, 8'h56);
        chk(cmpa, 16'h1256);
        i_cpu.wr16(t16_pkg::SEL_COMPARE_LOWER, 16'h5678);
        i_cpu.rd8(t16_pkg::SEL_COUNT_LOWER, b);
        i_cpu.rd8(t16_pkg::SEL_COMPARE_UPPER, b);
        chk({8'h00, b}, 16'h0056);
        i_cpu.rd8(t16_pkg::SEL_COUNT_UPPER, b);
        chk({8'h00, b}, 16'h0012);
        i_cpu.wr16(t16_pkg::SEL_CAPTURE_LOWER, 16'h0F0F);
        chk(cap, 16'h0000);
        $display("test access done");
    endtask : t_access

    task automatic t_count;
        wm_a = 2'h1;
        wm_b = 2'h1;
        cs = t16_pkg::CS_DIV1;
        oie = 1'b1;
        i_cpu.wr16(t16_pkg::SEL_COUNT_LOWER, 16'h00FD);
        chk(cnt, 16'h00FD);
        wt(ovf, 10, n0);
        chk(cnt, 16'h0000);
        tick(1);
        chk({15'h0, oirq}, 16'h0001);
        oclr = 1'b1;
        tick(1);
        oclr = 1'b0;
        tick(1);
        chk({15'h0, ovf}, 16'h0000);
        cs = t16_pkg::CS_STOP;
        wm_b = 2'h0;
        i_cpu.wr16(t16_pkg::SEL_COUNT_LOWER, 16'h00FE);
        cs = t16_pkg::CS_DIV1;
        n0 = 0;
        while (cnt !== 16'h00FF && n0 < 8) begin
            tick(1);
            n0++;
        end
        chk({15'h0, at_top}, 16'h0001);
        tick(1);
        chk(cnt, 16'h00FE);
        cs = t16_pkg::CS_STOP;
        wm_a = 2'h0;
        cs = t16_pkg::CS_EXT_RISE;
        i_cpu.wr16(t16_pkg::SEL_COUNT_LOWER, 16'hFFFF);
        ext = 1'b1;
        tick(6);
        chk(cnt, 16'h0000);
        chk({14'h0, at_floor, ovf}, 16'h0003);
        oack = 1'b1;
        tick(1);
        oack = 1'b0;
        ext = 1'b0;
        tick(6);
        chk(cnt, 16'h0000);
        chk({14'h0, at_top, ovf}, 16'h0000);
        cs = t16_pkg::CS_STOP;
        $display("test count done");
    endtask : t_count

    task automatic t_capture;
        cie = 1'b1;
        i_cpu.wr16(t16_pkg::SEL_COUNT_LOWER, 16'h4321);
        pin = 1'b1;
        wt(capf, 20, n0);
        chk(cap, 16'h4321);
        tick(1);
        chk({14'h0, cirq, capf}, 16'h0003);
        i_cpu.rd16(t16_pkg::SEL_CAPTURE_LOWER, r);
        chk(r, 16'h4321);
        cack = 1'b1;
        tick(1);
        cack = 1'b0;
        tick(1);
        chk({15'h0, capf}, 16'h0000);
        pin = 1'b0;
        tick(12);
        chk({15'h0, capf}, 16'h0000);
        er = 1'b0;
        i_cpu.wr16(t16_pkg::SEL_COUNT_LOWER, 16'h0777);
        pin = 1'b1;
        tick(8);
        pin = 1'b0;
        wt(capf, 20, n1);
        chk(cap, 16'h0777);
        // let the filter settle low so enabling it shows no false edge
        tick(8);
        er = 1'b1;
        clrcap();
        nf = 1'b1;
        pin = 1'b1;
        tick(2);
        pin = 1'b0;
        tick(12);
        chk({15'h0, capf}, 16'h0000);
        pin = 1'b1;
        wt(capf, 30, n1);
        chk(16'(n1 - n0), 16'h0004);
        clrcap();
        nf = 1'b0;
        $display("test capture done");
    endtask : t_capture

    task automatic t_sources;
        cts = 1'b1;
        tick(6);
        // the switch itself may capture, so the flag is cleared after it
        clrcap();
        i_cpu.wr16(t16_pkg::SEL_COUNT_LOWER, 16'h0ACE);
        cmp = 1'b1;
        wt(capf, 20, n1);
        chk(cap, 16'h0ACE);
        cts = 1'b0;
        pin = 1'b0;
        tick(6);
        clrcap();
        i_cpu.wr16(t16_pkg::SEL_COUNT_LOWER, 16'h0BEE);
        pout = 1'b1;
        pdir = 1'b1;
        wt(capf, 20, n1);
        chk(cap, 16'h0BEE);
        pdir = 1'b0;
        tick(6);
        clrcap();
        wm_b = 2'h3;
        i_cpu.wr16(t16_pkg::SEL_CAPTURE_LOWER, 16'h0040);
        chk(cap, 16'h0040);
        pin = 1'b1;
        tick(12);
        chk({15'h0, capf}, 16'h0000);
        $display("test sources done");
    endtask : t_sources

    initial begin
        {rst_n, nf, cts, cie, oie, cack, oack, cclr, oclr, ext, pin, pout, pdir, cmp} = '0;
        {cs, wm_a, wm_b} = '0;
        er = 1'b1;
        mismatches = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        tick(2);
        chk(cnt, 16'h0000);
        chk({14'h0, at_floor, ovf}, 16'h0002);
        t_access();
        t_count();
        t_capture();
        t_sources();
        test_done();
    end
endmodule : timer16_counter_capture_tb_top

`default_nettype wire
